/* common/rbr_pkg.sv */
// Shared constants for the receiver board readout register bank.
// Assumes a single 10 MHz system clock and a host port with byte offsets.
package rbr_pkg;
  localparam int RBR_NCH = 8;
  localparam int RBR_ADDR_W = 22;
  localparam int RBR_DATA_W = 32;

  // Baseboard register offsets
  localparam logic [21:0] OFS_COMMAND_STATUS = 22'h00_0000;
  localparam logic [21:0] OFS_FIFO_LEVEL_FLAGS = 22'h00_0004;
  localparam logic [21:0] OFS_IRQ_VECTOR = 22'h00_0008;
  localparam logic [21:0] OFS_IRQ_ENABLE_MASK = 22'h00_000C;
  localparam logic [21:0] OFS_IRQ_PENDING = 22'h00_0010;
  localparam logic [21:0] OFS_HEADER_FIRST_WORD = 22'h00_0014;
  localparam logic [21:0] OFS_HEADER_SECOND_WORD = 22'h00_0018;

  // Region codes on address bits 21:16, channel data top on bits 21:19, channel mode offsets on bits 15:0
  localparam logic [5:0] REG_BASEBOARD = 6'h00;
  localparam logic [5:0] REG_PAIR_FIRST = 6'h01;
  localparam logic [5:0] REG_PAIR_LAST = 6'h04;
  localparam logic [5:0] REG_HEADER = 6'h07;
  localparam logic [2:0] REG_CHAN_DATA_TOP = 3'h1;
  localparam logic [15:0] OFS_CHAN_MODE_LOW = 16'h0000;
  localparam logic [15:0] OFS_CHAN_MODE_HIGH = 16'h0004;

  // Command/status field positions
  localparam int CS_VME_ONLY = 0;
  localparam int CS_D64_2K = 1;
  localparam int CS_FREQ_LSB = 2;
  localparam int CS_EXT_EN = 4;
  localparam int CS_MULT_LO_LSB = 5;
  localparam int CS_MULT_HI_LSB = 7;
  localparam int CS_SOFT_SYNC = 9;
  localparam int CS_PKT_CLR = 10;
  localparam int CS_LBUS_RST = 11;
  localparam int CS_DONE_A = 12;
  localparam int CS_DONE_B = 13;
  localparam int CS_SETTLING = 14;
  localparam int CS_READBACK_LSB = 16;
  localparam int CS_HDR_EN = 19;

  // Reset values
  localparam logic [1:0] FREQ_RESET = 2'h0;
  localparam logic [1:0] MULT_RESET = 2'h0;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] READBACK_RESET = 3'h0;

  // Channel mode select values
  localparam logic [2:0] MODE_RAW = 3'h6;
  localparam logic [2:0] MODE_IQ_FIRST = 3'h2;
  localparam logic [2:0] MODE_IQ_LAST = 3'h5;

  // FIFO status codes and threshold
  localparam logic [3:0] FIFO_EMPTY = 4'h0;
  localparam logic [3:0] FIFO_LOW = 4'h1;
  localparam logic [3:0] FIFO_HALF = 4'h3;
  localparam logic [3:0] FIFO_FULL = 4'h7;
  localparam int FIFO_THRESH = 16;

  // PLL range codes driven out
  localparam logic [1:0] PLL_LOW = 2'h0;
  localparam logic [1:0] PLL_HIGH = 2'h1;
  localparam logic [1:0] PLL_MID = 2'h2;

  localparam logic [11:0] REBCAST_LONG = 12'h800;
  localparam logic [11:0] REBCAST_SHORT = 12'h100;
  localparam int HDR_GROUP_WORDS = 8;

  localparam int CLK_HZ = 10_000_000;
  localparam int PLL_SETTLE_MS = 15;
  localparam int PLL_SETTLE_CYCLES = (PLL_SETTLE_MS * CLK_HZ + 999) / 1000;

  typedef enum logic [1:0] {RBR_KIND_RAW, RBR_KIND_IQ, RBR_KIND_ACC} rbr_kind_e;
  typedef enum {RBR_HDR0, RBR_HDR1, RBR_DATA} rbr_stream_e;
endpackage : rbr_pkg

/* rtl/rbr_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides and a fill count.
// Assumes one clock; clear_i empties it synchronously.
`timescale 1ns/1ps
module rbr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("rbr_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready_o = (count_o != CW'(DEPTH));
  assign out_valid_o = (count_o != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || clear_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_o <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= rd_ptr + AW'(1);
      if (push && !pop)
        count_o <= count_o + CW'(1);
      else if (pop && !push)
        count_o <= count_o - CW'(1);
    end
  end
endmodule : rbr_fifo

/* rtl/rbr_readout_regs.sv */
// Readout register bank: address decode, per-channel packing and FIFOs,
// header insertion and baseboard command/status and FIFO flag registers.
// Assumes host strobes are one cycle wide and synchronous to sys_clk_i.
`timescale 1ns/1ps
module rbr_readout_regs import rbr_pkg::*; #(
  parameter int FIFO_DEPTH = 32,
  parameter int SETTLE_CYCLES = PLL_SETTLE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [RBR_ADDR_W-1:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [RBR_DATA_W-1:0] host_wdata_i,
  output logic [RBR_DATA_W-1:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic [RBR_NCH-1:0] smp_valid_i,
  input wire logic [RBR_NCH*32-1:0] smp_data_i,
  output logic [RBR_NCH-1:0] smp_ready_o,
  input wire logic trig_i,
  input wire logic ext_sync_i,
  output logic sync_o,
  input wire logic [RBR_NCH-1:0] over_range_i,
  input wire logic [15:0] ext_header_i,
  input wire logic dma_done_a_i,
  input wire logic dma_done_b_i,
  input wire logic [10:0] irq_pending_i,
  output logic fabric_enable_o,
  output logic d64_2k_o,
  output logic [11:0] rebroadcast_bytes_o,
  output logic [1:0] pll_range_o,
  output logic [2:0] rx_mult_lo_o,
  output logic [2:0] rx_mult_hi_o,
  output logic pll_settling_o,
  output logic local_reset_o,
  output logic [7:0] irq_vector_o,
  output logic [10:0] irq_enable_mask_o
);
  localparam int CW = $clog2(FIFO_DEPTH+1);
  localparam int SW = $clog2(SETTLE_CYCLES+1);
  initial
  begin
    if (FIFO_DEPTH <= FIFO_THRESH)
      $error("rbr_readout_regs: FIFO_DEPTH must exceed the status threshold");
    if (SETTLE_CYCLES < 1)
      $error("rbr_readout_regs: SETTLE_CYCLES must be at least 1");
  end

  function automatic rbr_kind_e pack_kind(input logic [2:0] mode);
    if (mode == MODE_RAW)
      return RBR_KIND_RAW;
    else if (mode >= MODE_IQ_FIRST && mode <= MODE_IQ_LAST)
      return RBR_KIND_IQ;
    else
      return RBR_KIND_ACC;
  endfunction : pack_kind
  function automatic logic [2:0] mult_factor(input logic [1:0] code);
    case (code)
      2'h1: return 3'h2;
      2'h2: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction : mult_factor
  function automatic logic [3:0] fifo_code(input logic [CW-1:0] cnt);
    if (cnt == '0)
      return FIFO_EMPTY;
    else if (cnt == CW'(FIFO_DEPTH))
      return FIFO_FULL;
    else if (cnt >= CW'(FIFO_THRESH))
      return FIFO_HALF;
    else
      return FIFO_LOW;
  endfunction : fifo_code
  // Command/status state
  logic vme_only, d64_2k, ext_en, hdr_en;
  logic [1:0] freq_sel, mult_lo, mult_hi;
  logic [2:0] readback, grp_cnt, pair_chan;
  logic [7:0] irq_vector;
  logic [10:0] irq_enable_mask;
  logic [2:0] chan_mode [RBR_NCH];
  logic [23:0] pkt_cnt;
  logic [SW-1:0] settle_cnt;
  rbr_stream_e stream_state;
  // Decode
  logic [5:0] region;
  logic wr_csr, pair_hit, fifo_space, chan_data_space, stream_data;
  logic [RBR_NCH-1:0] fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [31:0] fifo_in_data [RBR_NCH], fifo_out_data [RBR_NCH];
  logic [CW-1:0] fifo_count [RBR_NCH];
  logic [31:0] header_first_word, header_second_word, flags_word, csr_word, next_rdata;

  assign region = host_addr_i[21:16];
  assign wr_csr = host_wr_i && (host_addr_i == OFS_COMMAND_STATUS);
  assign pair_hit = (region >= REG_PAIR_FIRST) && (region <= REG_PAIR_LAST) &&
                    ((host_addr_i[15:0] == OFS_CHAN_MODE_LOW) ||
                     (host_addr_i[15:0] == OFS_CHAN_MODE_HIGH));
  assign pair_chan = {region[1:0] - 2'h1, host_addr_i[2]};
  assign fifo_space = (host_addr_i[21:20] != 2'h0);
  assign chan_data_space = (host_addr_i[21:19] == REG_CHAN_DATA_TOP);
  assign stream_data = !hdr_en || (stream_state == RBR_DATA);
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      vme_only <= 1'b0;
      d64_2k <= 1'b0;
      freq_sel <= FREQ_RESET;
      ext_en <= 1'b0;
      mult_lo <= MULT_RESET;
      mult_hi <= MULT_RESET;
      readback <= READBACK_RESET;
      hdr_en <= 1'b0;
    end
    else if (wr_csr)
    begin
      vme_only <= host_wdata_i[CS_VME_ONLY];
      d64_2k <= host_wdata_i[CS_D64_2K];
      freq_sel <= host_wdata_i[CS_FREQ_LSB +: 2];
      ext_en <= host_wdata_i[CS_EXT_EN];
      mult_lo <= host_wdata_i[CS_MULT_LO_LSB +: 2];
      mult_hi <= host_wdata_i[CS_MULT_HI_LSB +: 2];
      readback <= host_wdata_i[CS_READBACK_LSB +: 3];
      hdr_en <= host_wdata_i[CS_HDR_EN];
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      irq_vector <= '0;
      irq_enable_mask <= '0;
    end
    else if (host_wr_i && host_addr_i == OFS_IRQ_VECTOR)
      irq_vector <= host_wdata_i[7:0];
    else if (host_wr_i && host_addr_i == OFS_IRQ_ENABLE_MASK)
      irq_enable_mask <= host_wdata_i[10:0];
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < RBR_NCH; i++)
        chan_mode[i] <= MODE_RESET;
    end
    else if (host_wr_i && pair_hit)
      chan_mode[pair_chan] <= host_wdata_i[2:0];
  end
  // Write-only pulse; the readout path below is the local logic it clears
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      local_reset_o <= 1'b0;
    else
      local_reset_o <= wr_csr && host_wdata_i[CS_LBUS_RST];
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || (wr_csr && (host_wdata_i[CS_SOFT_SYNC] || host_wdata_i[CS_PKT_CLR])))
      pkt_cnt <= '0;
    else if (trig_i)
      pkt_cnt <= pkt_cnt + 24'h1;
  end
  // Busy flag lets software poll instead of timing the settle itself
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      settle_cnt <= '0;
    else if (wr_csr && ((host_wdata_i[CS_FREQ_LSB +: 2] != freq_sel) ||
                        (host_wdata_i[CS_MULT_LO_LSB +: 2] != mult_lo) ||
                        (host_wdata_i[CS_MULT_HI_LSB +: 2] != mult_hi)))
      settle_cnt <= SW'(SETTLE_CYCLES);
    else if (settle_cnt != '0)
      settle_cnt <= settle_cnt - SW'(1);
  end
  assign pll_settling_o = (settle_cnt != '0);
  assign sync_o = ext_sync_i && ext_en;
  assign fabric_enable_o = !vme_only;
  assign d64_2k_o = d64_2k;
  assign rebroadcast_bytes_o = d64_2k ? REBCAST_LONG : REBCAST_SHORT;
  assign pll_range_o = (freq_sel == 2'h0) ? PLL_LOW :
                       (freq_sel == 2'h1) ? PLL_HIGH : PLL_MID;
  assign rx_mult_lo_o = mult_factor(mult_lo);
  assign rx_mult_hi_o = mult_factor(mult_hi);
  assign irq_vector_o = irq_vector;
  assign irq_enable_mask_o = irq_enable_mask;
  // Per-channel packing ahead of each FIFO
  for (genvar ch = 0; ch < RBR_NCH; ch++)
  begin : g_chan
    logic phase;
    logic [15:0] half;
    logic [31:0] smp;
    rbr_kind_e kind;
    assign smp = smp_data_i[ch*32 +: 32];
    assign kind = pack_kind(chan_mode[ch]);
    always_comb
    begin
      fifo_in_valid[ch] = smp_valid_i[ch];
      fifo_in_data[ch] = smp;
      smp_ready_o[ch] = fifo_in_ready[ch];
      case (kind)
        RBR_KIND_RAW:
        begin
          fifo_in_valid[ch] = smp_valid_i[ch] && phase;
          fifo_in_data[ch] = {smp[15:0], half};
          smp_ready_o[ch] = !phase || fifo_in_ready[ch];
        end
        RBR_KIND_IQ:
          fifo_in_data[ch] = {smp[31:16], smp[15:0]};
        default:
          fifo_in_data[ch] = smp;
      endcase
    end
    // Half word holds the earlier raw sample until its partner arrives
    always_ff @(posedge sys_clk_i)
    begin
      if (srst_i || local_reset_o || kind != RBR_KIND_RAW)
      begin
        phase <= 1'b0;
        half <= '0;
      end
      else if (smp_valid_i[ch] && smp_ready_o[ch])
      begin
        phase <= !phase;
        if (!phase)
          half <= smp[15:0];
      end
    end
    assign fifo_out_ready[ch] = host_rd_i &&
      ((fifo_space && stream_data && readback == 3'(ch)) ||
       (chan_data_space && host_addr_i[18:16] == 3'(ch)));
    rbr_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .clear_i(local_reset_o),
      .in_valid_i(fifo_in_valid[ch]),
      .in_ready_o(fifo_in_ready[ch]),
      .in_data_i(fifo_in_data[ch]),
      .out_valid_o(fifo_out_valid[ch]),
      .out_ready_i(fifo_out_ready[ch]),
      .out_data_o(fifo_out_data[ch]),
      .count_o(fifo_count[ch])
    );
    assign flags_word[ch*4 +: 4] = fifo_code(fifo_count[ch]);
  end

  assign header_first_word = {over_range_i, pkt_cnt};
  assign header_second_word = {~fifo_out_valid, ~fifo_in_ready, ext_header_i};
  always_comb
  begin
    csr_word = '0;
    csr_word[CS_VME_ONLY] = vme_only;
    csr_word[CS_D64_2K] = d64_2k;
    csr_word[CS_FREQ_LSB +: 2] = freq_sel;
    csr_word[CS_EXT_EN] = ext_en;
    csr_word[CS_MULT_LO_LSB +: 2] = mult_lo;
    csr_word[CS_MULT_HI_LSB +: 2] = mult_hi;
    csr_word[CS_DONE_A] = dma_done_a_i;
    csr_word[CS_DONE_B] = dma_done_b_i;
    csr_word[CS_SETTLING] = pll_settling_o;
    csr_word[CS_READBACK_LSB +: 3] = readback;
    csr_word[CS_HDR_EN] = hdr_en;
  end
  // Header position advances only on stream reads, so per-channel reads do not disturb it
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || local_reset_o || !hdr_en)
    begin
      stream_state <= RBR_HDR0;
      grp_cnt <= '0;
    end
    else if (host_rd_i && fifo_space)
    begin
      case (stream_state)
        RBR_HDR0: stream_state <= RBR_HDR1;
        RBR_HDR1:
        begin
          stream_state <= RBR_DATA;
          grp_cnt <= '0;
        end
        RBR_DATA:
        begin
          grp_cnt <= grp_cnt + 3'h1;
          if (grp_cnt == 3'(HDR_GROUP_WORDS - 1))
            stream_state <= RBR_HDR0;
        end
        default: stream_state <= RBR_HDR0;
      endcase
    end
  end
  always_comb
  begin
    next_rdata = '0;
    if (fifo_space)
    begin
      if (!stream_data)
        next_rdata = (stream_state == RBR_HDR0) ? header_first_word : header_second_word;
      else if (fifo_out_valid[readback])
        next_rdata = fifo_out_data[readback];
    end
    else if (chan_data_space)
    begin
      if (fifo_out_valid[host_addr_i[18:16]])
        next_rdata = fifo_out_data[host_addr_i[18:16]];
    end
    else if (region == REG_HEADER)
      next_rdata = host_addr_i[2] ? header_second_word : header_first_word;
    else if (pair_hit)
      next_rdata = {29'h0, chan_mode[pair_chan]};
    else if (region == REG_BASEBOARD)
    begin
      case (host_addr_i)
        OFS_COMMAND_STATUS: next_rdata = csr_word;
        OFS_FIFO_LEVEL_FLAGS: next_rdata = flags_word;
        OFS_IRQ_VECTOR: next_rdata = {24'h0, irq_vector};
        OFS_IRQ_ENABLE_MASK: next_rdata = {21'h0, irq_enable_mask};
        OFS_IRQ_PENDING: next_rdata = {21'h0, irq_pending_i};
        OFS_HEADER_FIRST_WORD: next_rdata = header_first_word;
        OFS_HEADER_SECOND_WORD: next_rdata = header_second_word;
        default: next_rdata = '0;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      host_rdata_o <= '0;
      host_rvalid_o <= 1'b0;
    end
    else
    begin
      host_rvalid_o <= host_rd_i;
      if (host_rd_i)
        host_rdata_o <= next_rdata;
    end
  end
endmodule : rbr_readout_regs

/* testbench/rbr_readout_properties.sv */
// Concurrent checks on the readout register bank host port and controls.
// Assumes it is bound onto rbr_readout_regs; one clock, sync reset.
`timescale 1ns/1ps
module rbr_readout_properties import rbr_pkg::*; #(
  parameter int FIFO_DEPTH = 32,
  parameter int SETTLE_CYCLES = PLL_SETTLE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [RBR_ADDR_W-1:0] host_addr_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [RBR_DATA_W-1:0] host_wdata_i,
  input wire logic [RBR_DATA_W-1:0] host_rdata_o,
  input wire logic host_rvalid_o,
  input wire logic ext_sync_i,
  input wire logic sync_o,
  input wire logic dma_done_a_i,
  input wire logic dma_done_b_i,
  input wire logic fabric_enable_o,
  input wire logic d64_2k_o,
  input wire logic [11:0] rebroadcast_bytes_o,
  input wire logic [1:0] pll_range_o,
  input wire logic [2:0] rx_mult_lo_o,
  input wire logic [2:0] rx_mult_hi_o,
  input wire logic local_reset_o
);
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  logic csr_wr;
  logic csr_rd;
  assign csr_wr = host_wr_i && host_addr_i == OFS_COMMAND_STATUS;
  assign csr_rd = host_rd_i && host_addr_i == OFS_COMMAND_STATUS;
  // Codes 00 and 11 both mean equal clocks
  function automatic logic [2:0] fac(input logic [1:0] c);
    return {c == 2'h2, c == 2'h1, c[1] == c[0]};
  endfunction : fac
  a_read_answer: assert property (host_rd_i |=> host_rvalid_o)
    else $error("read got no answer");
  a_fabric_path: assert property (csr_wr |=> fabric_enable_o == !$past(host_wdata_i[0]))
    else $error("fabric enable wrong");
  a_rebcast_size: assert property (rebroadcast_bytes_o == (d64_2k_o ? 12'h800 : 12'h100))
    else $error("rebroadcast size wrong");
  a_pll_code: assert property (csr_wr |=> pll_range_o ==
    {$past(host_wdata_i[3]), $past(host_wdata_i[2]) & !$past(host_wdata_i[3])})
    else $error("pll range wrong");
  a_mult_low: assert property (csr_wr |=> rx_mult_lo_o == fac($past(host_wdata_i[6:5])))
    else $error("low multiplier wrong");
  a_mult_high: assert property (csr_wr |=> rx_mult_hi_o == fac($past(host_wdata_i[8:7])))
    else $error("high multiplier wrong");
  a_sync_gate: assert property (sync_o |-> ext_sync_i)
    else $error("sync passed without input");
  a_lbus_pulse: assert property (csr_wr && host_wdata_i[11] |=> local_reset_o ##1 !local_reset_o)
    else $error("local reset pulse wrong");
  a_done_bits: assert property (csr_rd |=>
    host_rdata_o[13:12] == $past({dma_done_b_i, dma_done_a_i}))
    else $error("done bits wrong");
  a_flags_code: assert property (host_rd_i && host_addr_i == OFS_FIFO_LEVEL_FLAGS |=>
    (host_rdata_o & 32'h8888_8888) == 32'h0)
    else $error("flag code out of set");
  c_lreset: cover property (local_reset_o);
  c_sync: cover property (sync_o);
  c_stream: cover property (host_rd_i && host_addr_i >= 22'h10_0000);
endmodule : rbr_readout_properties

/* testbench/rbr_host_model.sv */
// Host bus master model: one-cycle read and write strobes.
// Assumes the block answers a read one edge after the strobe.
`timescale 1ns/1ps
module rbr_host_model import rbr_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic [RBR_DATA_W-1:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic settling_i,
  output logic [RBR_ADDR_W-1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [RBR_DATA_W-1:0] wdata_o
);
  initial
  begin
    addr_o <= '0;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    wdata_o <= '0;
  end
  task automatic wr(input logic [21:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    // Released lines carry no stale value
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [21:0] a, output logic [31:0] d, output logic v);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    // Answer is taken at the edge where valid is sampled high
    @(posedge sys_clk_i);
    d = rdata_i;
    v = rvalid_i;
  endtask : rd
  // Software waits out PLL settling after clock changes
  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    for (int i = 0; i < 1000 && settling_i; i++) @(posedge sys_clk_i);
  endtask : settle
endmodule : rbr_host_model

/* testbench/rbr_readout_regs_test.sv */
// Self-checking bench for the readout register bank.
// Host accesses go through the host model; samples are driven here.
`timescale 1ns/1ps
module rbr_readout_regs_test import rbr_pkg::*; ();
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [21:0] host_addr_i;
  logic host_wr_i, host_rd_i, host_rvalid_o, vv;
  logic [31:0] host_wdata_i, host_rdata_o, rv;
  logic [7:0] smp_valid_i = '0, smp_ready_o, over_range_i = 8'hA5, irq_vector_o;
  logic [255:0] smp_data_i = '0;
  logic trig_i = 1'b0, ext_sync_i = 1'b0, dma_done_a_i = 1'b1, dma_done_b_i = 1'b0;
  logic sync_o, fabric_enable_o, d64_2k_o, pll_settling_o, local_reset_o;
  logic [15:0] ext_header_i = 16'hBEEF;
  logic [10:0] irq_pending_i = 11'h5A5, irq_enable_mask_o;
  logic [11:0] rebroadcast_bytes_o;
  logic [1:0] pll_range_o;
  logic [2:0] rx_mult_lo_o, rx_mult_hi_o;
  int fail_count = 0, checked = 0, cyc = 0;

  always #50 sys_clk_i = ~sys_clk_i;

  rbr_readout_regs #(.FIFO_DEPTH(32), .SETTLE_CYCLES(5)) dut (.sys_clk_i(sys_clk_i),
    .srst_i(srst_i), .host_addr_i(host_addr_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
    .smp_valid_i(smp_valid_i), .smp_data_i(smp_data_i), .smp_ready_o(smp_ready_o),
    .trig_i(trig_i), .ext_sync_i(ext_sync_i), .sync_o(sync_o), .over_range_i(over_range_i),
    .ext_header_i(ext_header_i), .dma_done_a_i(dma_done_a_i), .dma_done_b_i(dma_done_b_i),
    .irq_pending_i(irq_pending_i), .fabric_enable_o(fabric_enable_o), .d64_2k_o(d64_2k_o),
    .rebroadcast_bytes_o(rebroadcast_bytes_o), .pll_range_o(pll_range_o),
    .rx_mult_lo_o(rx_mult_lo_o), .rx_mult_hi_o(rx_mult_hi_o), .pll_settling_o(pll_settling_o),
    .local_reset_o(local_reset_o), .irq_vector_o(irq_vector_o),
    .irq_enable_mask_o(irq_enable_mask_o));

  rbr_host_model host (.sys_clk_i(sys_clk_i), .rdata_i(host_rdata_o), .rvalid_i(host_rvalid_o),
    .settling_i(pll_settling_o), .addr_o(host_addr_i), .wr_o(host_wr_i), .rd_o(host_rd_i),
    .wdata_o(host_wdata_i));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [21:0] a, input logic [31:0] exp);
    host.rd(a, rv, vv);
    chk(n, rv, exp);
    chk("rvalid", 32'(vv), 32'h1);
  endtask : rchk

  // Valid holds until ready is seen between edges, so the taking edge is known
  task automatic push(input int ch, input logic [31:0] d);
    @(posedge sys_clk_i);
    smp_valid_i[ch] <= 1'b1;
    smp_data_i[ch*32+:32] <= d;
    #1;
    while (!smp_ready_o[ch]) @(posedge sys_clk_i) #1;
    @(posedge sys_clk_i);
    smp_valid_i[ch] <= 1'b0;
    smp_data_i[ch*32+:32] <= ~d;
  endtask : push

  task automatic t_reset();
    rchk("csr", OFS_COMMAND_STATUS, 32'h0000_1000);
    chk("fabric", 32'(fabric_enable_o), 32'h1);
    chk("rebcast", 32'(rebroadcast_bytes_o), 32'h100);
    rchk("flags", OFS_FIFO_LEVEL_FLAGS, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_csr();
    logic [31:0] v;
    logic [1:0] pll_e [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
    logic [2:0] mul_e [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
    ext_sync_i <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      v = {23'h0, c[1:0], c[1:0], 1'b1, c[1:0], 2'h3};
      host.wr(OFS_COMMAND_STATUS, v);
      host.settle();
      rchk("csr", OFS_COMMAND_STATUS, v | 32'h1000);
      chk("pll", 32'(pll_range_o), 32'(pll_e[c]));
      chk("mult lo", 32'(rx_mult_lo_o), 32'(mul_e[c]));
      chk("mult hi", 32'(rx_mult_hi_o), 32'(mul_e[c]));
      chk("sync", 32'(sync_o), 32'h1);
    end
    chk("fabric", 32'(fabric_enable_o), 32'h0);
    chk("rebcast", 32'(rebroadcast_bytes_o), 32'h800);
    chk("d64", 32'(d64_2k_o), 32'h1);
    dma_done_b_i <= 1'b1;
    host.wr(OFS_COMMAND_STATUS, 32'h0);
    rchk("settling", OFS_COMMAND_STATUS, 32'h0000_7000);
    host.settle();
    chk("sync idle", 32'(sync_o), 32'h0);
    rchk("done", OFS_COMMAND_STATUS, 32'h0000_3000);
    host.wr(OFS_COMMAND_STATUS, 32'h800);
    #1;
    chk("lreset", 32'(local_reset_o), 32'h1);
    host.wr(OFS_IRQ_VECTOR, 32'hFFFF_FFA5);
    rchk("vector", OFS_IRQ_VECTOR, 32'hA5);
    chk("vector out", 32'(irq_vector_o), 32'hA5);
    host.wr(OFS_IRQ_ENABLE_MASK, 32'hFFFF_FFFF);
    rchk("mask", OFS_IRQ_ENABLE_MASK, 32'h7FF);
    chk("mask out", 32'(irq_enable_mask_o), 32'h7FF);
    host.wr(OFS_IRQ_PENDING, 32'h0);
    rchk("pending", OFS_IRQ_PENDING, 32'h5A5);
    rchk("unmapped", 22'h05_0000, 32'h0);
    $display("test csr done");
  endtask : t_csr

  task automatic t_modes();
    host.wr(22'h01_0000, 32'h6);
    host.wr(22'h01_0004, 32'h2);
    rchk("mode0", 22'h01_0000, 32'h6);
    rchk("mode1", 22'h01_0004, 32'h2);
    push(0, 32'h0000_8001);
    push(0, 32'h0000_7FFE);
    push(1, 32'hF00D_1234);
    rchk("raw", 22'h08_0000, 32'h7FFE_8001);
    rchk("iq", 22'h09_0000, 32'hF00D_1234);
    host.wr(OFS_COMMAND_STATUS, 32'h0002_0000);
    push(2, 32'h8000_0001);
    push(2, 32'h7FFF_FFFF);
    rchk("acc", 22'h10_0000, 32'h8000_0001);
    rchk("acc top", 22'h3F_FFFC, 32'h7FFF_FFFF);
    $display("test modes done");
  endtask : t_modes

  task automatic t_fifo();
    for (int i = 0; i < 15; i++) push(3, i);
    rchk("flags 15", OFS_FIFO_LEVEL_FLAGS, 32'h0000_1000);
    push(3, 15);
    rchk("flags 16", OFS_FIFO_LEVEL_FLAGS, 32'h0000_3000);
    for (int i = 16; i < 32; i++) push(3, i);
    #1;
    chk("refuse", 32'(smp_ready_o[3]), 32'h0);
    rchk("flags full", OFS_FIFO_LEVEL_FLAGS, 32'h0000_7000);
    for (int i = 0; i < 32; i++) rchk("drain", 22'h0B_0000, i);
    push(4, 32'h44);
    rchk("flags ch4", OFS_FIFO_LEVEL_FLAGS, 32'h0001_0000);
    rchk("ch4", 22'h0C_0000, 32'h44);
    rchk("flags empty", OFS_FIFO_LEVEL_FLAGS, 32'h0);
    push(5, 32'h55);
    host.wr(OFS_COMMAND_STATUS, 32'h800);
    rchk("lreset clears", OFS_FIFO_LEVEL_FLAGS, 32'h0);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_header();
    host.wr(OFS_COMMAND_STATUS, 32'h400);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk_i);
      trig_i <= (i % 2 == 0);
    end
    host.wr(OFS_COMMAND_STATUS, 32'h000A_0000);
    for (int i = 0; i < 8; i++) push(2, 32'hA000_0000 + i);
    rchk("hdr0", 22'h10_0000, 32'hA500_0003);
    rchk("hdr1", 22'h10_0000, 32'hFB00_BEEF);
    for (int i = 0; i < 8; i++) rchk("data", 22'h10_0000, 32'hA000_0000 + i);
    rchk("hdr0 again", 22'h10_0000, 32'hA500_0003);
    rchk("head reg", OFS_HEADER_FIRST_WORD, 32'hA500_0003);
    host.wr(OFS_COMMAND_STATUS, 32'h000A_0200);
    rchk("soft sync", OFS_HEADER_FIRST_WORD, 32'hA500_0000);
    @(posedge sys_clk_i);
    trig_i <= 1'b1;
    @(posedge sys_clk_i);
    trig_i <= 1'b0;
    rchk("one trig", OFS_HEADER_FIRST_WORD, 32'hA500_0001);
    host.wr(OFS_COMMAND_STATUS, 32'h400);
    rchk("pkt clear", OFS_HEADER_FIRST_WORD, 32'hA500_0000);
    $display("test header done");
  endtask : t_header

  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_csr();
    t_modes();
    t_fifo();
    t_header();
    wrap_up();
  end
endmodule : rbr_readout_regs_test

bind rbr_readout_regs rbr_readout_properties #(.FIFO_DEPTH(FIFO_DEPTH),
  .SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .host_addr_i(host_addr_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
  .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
  .ext_sync_i(ext_sync_i), .sync_o(sync_o), .dma_done_a_i(dma_done_a_i),
  .dma_done_b_i(dma_done_b_i), .fabric_enable_o(fabric_enable_o), .d64_2k_o(d64_2k_o),
  .rebroadcast_bytes_o(rebroadcast_bytes_o), .pll_range_o(pll_range_o),
  .rx_mult_lo_o(rx_mult_lo_o), .rx_mult_hi_o(rx_mult_hi_o), .local_reset_o(local_reset_o));
